// ---- common/bpfm_pkg.sv ----
/*
 * Constants, packet layout, register map and state codes of the
 * pattern-fill / mono-text raster datapath.
 * Assumes one clock, 8 bits per pixel, 32-bit command stream words.
 */
package bpfm_pkg;
	// ----------------------------------------------------------------
	// command packet layout
	// ----------------------------------------------------------------
	localparam logic [7:0] BPFM_OP_FILL     = 8'h01;
	localparam logic [7:0] BPFM_OP_SETUP    = 8'h02;
	localparam logic [7:0] BPFM_OP_TEXT     = 8'h03;
	localparam logic [2:0] BPFM_ARGS_FILL   = 3'h4;
	localparam logic [2:0] BPFM_ARGS_SETUP  = 3'h6;
	localparam logic [2:0] BPFM_ARGS_TEXT   = 3'h2;
	localparam int         BPFM_HDR_OP      = 24;
	localparam int         BPFM_HDR_ROP     = 16;
	localparam int         BPFM_HDR_SRCSEL  = 15;
	localparam int         BPFM_HDR_VALIGN  = 12;
	localparam int         BPFM_HDR_DYNEN   = 11;
	localparam int         BPFM_HDR_DYNDEP  = 9;
	localparam logic [1:0] BPFM_DEPTH_8BPP  = 2'h0;
	localparam logic       BPFM_SRC_STREAM  = 1'h1;
	// ----------------------------------------------------------------
	// raster operation codes and pattern geometry
	// ----------------------------------------------------------------
	localparam logic [7:0] BPFM_ROP_PAT     = 8'hf0;
	localparam logic [7:0] BPFM_ROP_SRC     = 8'hcc;
	localparam logic [6:0] BPFM_PAT_LAST    = 7'h3f;
	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	localparam logic [7:0] BPFM_REG_CTRL    = 8'h00;
	localparam logic [7:0] BPFM_REG_STATUS  = 8'h04;
	localparam logic [7:0] BPFM_REG_DONE    = 8'h08;
	localparam int         BPFM_CTRL_RUN    = 0;
	localparam int         BPFM_STAT_BUSY   = 0;
	localparam int         BPFM_STAT_ERR    = 1;
	localparam logic       BPFM_RUN_RST     = 1'h0;
	// ----------------------------------------------------------------
	// engine states
	// ----------------------------------------------------------------
	typedef enum logic [9:0] {
		S_IDLE = 10'h001,
		S_ARG  = 10'h002,
		S_GO   = 10'h004,
		S_PAT  = 10'h008,
		S_PATW = 10'h010,
		S_PIX  = 10'h020,
		S_RDD  = 10'h040,
		S_DWT  = 10'h080,
		S_WR   = 10'h100,
		S_NXT  = 10'h200
	} bpfm_state_t;
endpackage

// ---- design/bpfm_engine.sv ----
/*
 * Raster datapath: tiled 8x8 colour pattern fill and clipped mono
 * text drawn from glyph words carried in the command stream.
 * Assumes a memory port on CLK that takes a read or write each cycle
 * and returns read data later with MEM_RVALID.
 */
// The address-and-strobe port and the address map were decided locally.
// Notes on behaviour
// - raster code F0h writes the pattern pixel unchanged
// - operations without source input never read source from memory
// - raster code CCh writes the source pixel unchanged
// - operations without pattern input never read the pattern
// - pattern base uses address bits 31..3 only, quadword aligned
// - destination address is the byte address of the first write
// - vertical alignment zero maps pattern top row to first line
// - 8bpp colour pattern needs dynamic colour on with depth zero
// - the 8x8 pattern tiles across the whole rectangle
// - each new line advances the destination by the pitch in bytes
// - linear fill: height counts lines, width counts bytes
// - text source select one takes glyph data from the stream
// - immediate glyph has no source address and is bit packed
// - only text pixels inside the inclusive clip rectangle are written; fills ignore the clip rectangle
// - mono source uses no byte pitch between lines
// - at 8bpp only bits 7..0 of expansion colours count
// - pixels whose glyph bit is zero are never written
// - text uses start and end X and Y, not width and height
// - state not needed by the current packet is ignored
// - glyph bit one gives foreground, zero leaves the destination pixel unwritten
module bpfm_engine
	import bpfm_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [31:0] REG_RDATA,
	input  wire logic [31:0] CMD_DATA,
	input  wire logic        CMD_VALID,
	output logic             CMD_READY,
	output logic             MEM_RD,
	output logic             MEM_WR,
	output logic      [31:0] MEM_ADDR,
	output logic      [7:0]  MEM_WDATA,
	input  wire logic [7:0]  MEM_RDATA,
	input  wire logic        MEM_RVALID,
	output logic             BUSY
);
	// ----------------------------------------------------------------
	// state and storage
	// ----------------------------------------------------------------
	bpfm_state_t st_q;
	logic        gly_q;
	logic [31:0] arg_q [0:5];
	logic [2:0]  argi_q, nargs_q;
	logic [31:0] hdr_q;
	logic        is_text_q;
	logic [7:0]  pat_q [0:63];
	logic [6:0]  pcnt_q;
	logic [15:0] x_q, y_q, xs_q, xe_q, ye_q, pitch_q;
	logic [31:0] line_q, addr_q;
	logic [7:0]  wdata_q;
	logic [31:0] gw_q;
	logic        gv_q;
	logic [4:0]  k_q;
	logic [15:0] spitch_q, cx1_q, cy1_q, cx2_q, cy2_q;
	logic [31:0] fg_q, bg_q, base_q;
	logic [7:0]  srop_q;
	logic        run_q, err_q;
	logic [31:0] done_q;

	function automatic logic [7:0] bpfm_rop(input logic [7:0] code, input logic [7:0] p,
		input logic [7:0] s, input logic [7:0] d);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			r[i] = code[{p[i], s[i], d[i]}];
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// decode of the current operation
	// ----------------------------------------------------------------
	logic [7:0]  rop_c, pix_pat, pix_src;
	logic        uses_p, uses_d, gbit, in_clip, wen, line_end, last_px;
	logic [2:0]  prow;
	logic [31:0] pix_addr, pbase;
	logic [7:0]  op_in;
	logic        take_hdr;

	assign op_in    = CMD_DATA[BPFM_HDR_OP +: 8];
	assign take_hdr = st_q == S_IDLE && run_q && CMD_VALID;
	assign rop_c    = is_text_q ? srop_q : hdr_q[BPFM_HDR_ROP +: 8];
	assign uses_p   = rop_c[7:4] != rop_c[3:0];
	assign uses_d   = {rop_c[7], rop_c[5], rop_c[3], rop_c[1]} != {rop_c[6], rop_c[4], rop_c[2], rop_c[0]};
	assign pbase    = {arg_q[3][31:3], 3'h0};
	assign prow     = y_q[2:0] + hdr_q[BPFM_HDR_VALIGN +: 3];
	assign pix_pat  = is_text_q ? 8'h00 : pat_q[{prow, x_q[2:0]}];
	assign gbit     = gw_q[{k_q[4:3], ~k_q[2:0]}];
	assign pix_src  = is_text_q ? (gbit ? fg_q[7:0] : bg_q[7:0]) : 8'h00;
	assign in_clip  = x_q >= cx1_q && x_q <= cx2_q && y_q >= cy1_q && y_q <= cy2_q;
	assign wen      = is_text_q ? (gbit && in_clip) : 1'b1;
	assign pix_addr = line_q + {16'h0000, x_q};
	assign line_end = x_q == xe_q;
	assign last_px  = line_end && y_q == ye_q;

	assign CMD_READY = (st_q == S_IDLE && run_q) || st_q == S_ARG || gly_q;
	assign MEM_RD    = st_q == S_PAT || st_q == S_RDD;
	assign MEM_WR    = st_q == S_WR;
	assign MEM_ADDR  = addr_q;
	assign MEM_WDATA = wdata_q;
	assign BUSY      = st_q != S_IDLE;

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			st_q    <= S_IDLE;
			gly_q   <= 1'b0;
			argi_q  <= 3'h0;
			nargs_q <= 3'h0;
			hdr_q   <= 32'h0;
			is_text_q <= 1'b0;
			pcnt_q  <= 7'h0;
			gv_q    <= 1'b0;
			gw_q    <= 32'h0;
			k_q     <= 5'h0;
		end else begin
			case (st_q)
				S_IDLE: begin
					if (take_hdr) begin
						hdr_q     <= CMD_DATA;
						is_text_q <= op_in == BPFM_OP_TEXT;
						argi_q    <= 3'h0;
						// unknown opcodes are dropped after the header word
						if (op_in == BPFM_OP_FILL) begin
							nargs_q <= BPFM_ARGS_FILL;
							st_q    <= S_ARG;
						end else if (op_in == BPFM_OP_SETUP) begin
							nargs_q <= BPFM_ARGS_SETUP;
							st_q    <= S_ARG;
						end else if (op_in == BPFM_OP_TEXT) begin
							nargs_q <= BPFM_ARGS_TEXT;
							st_q    <= S_ARG;
						end
					end
				end
				S_ARG: begin
					if (CMD_VALID) begin
						argi_q <= argi_q + 3'h1;
						if (argi_q + 3'h1 == nargs_q) begin
							st_q <= S_GO;
						end
					end
				end
				S_GO: begin
					pcnt_q <= 7'h0;
					if (hdr_q[BPFM_HDR_OP +: 8] == BPFM_OP_SETUP) begin
						st_q <= S_IDLE;
					end else if (is_text_q) begin
						if (hdr_q[BPFM_HDR_SRCSEL] != BPFM_SRC_STREAM || arg_q[1][15:0] < arg_q[0][15:0]
							|| arg_q[1][31:16] < arg_q[0][31:16]) begin
							st_q <= S_IDLE;
						end else begin
							st_q <= S_PIX;
						end
					end else if (arg_q[1][31:16] == 16'h0 || arg_q[1][15:0] == 16'h0) begin
						st_q <= S_IDLE;
					end else if (uses_p) begin
						if (hdr_q[BPFM_HDR_DYNEN] && hdr_q[BPFM_HDR_DYNDEP +: 2] == BPFM_DEPTH_8BPP) begin
							st_q <= S_PAT;
						end else begin
							st_q <= S_IDLE;
						end
					end else begin
						st_q <= S_PIX;
					end
				end
				S_PAT: begin
					st_q <= S_PATW;
				end
				S_PATW: begin
					if (MEM_RVALID) begin
						pcnt_q <= pcnt_q + 7'h1;
						st_q   <= pcnt_q == BPFM_PAT_LAST ? S_PIX : S_PAT;
					end
				end
				S_PIX: begin
					if (is_text_q && !gv_q) begin
						gly_q <= 1'b1;
						if (gly_q && CMD_VALID) begin
							gw_q  <= CMD_DATA;
							gv_q  <= 1'b1;
							k_q   <= 5'h0;
							gly_q <= 1'b0;
						end
					end else if (wen) begin
						st_q <= uses_d ? S_RDD : S_WR;
					end else begin
						st_q <= S_NXT;
					end
				end
				S_RDD: begin
					st_q <= S_DWT;
				end
				S_DWT: begin
					if (MEM_RVALID) begin
						st_q <= S_WR;
					end
				end
				S_WR: begin
					st_q <= S_NXT;
				end
				S_NXT: begin
					if (is_text_q) begin
						k_q <= k_q + 5'h1;
						if (k_q == 5'h1f) begin
							gv_q <= 1'b0;
						end
					end
					if (last_px) begin
						// padding bits left in the last glyph word are dropped
						gv_q <= 1'b0;
						st_q <= S_IDLE;
					end else begin
						st_q <= S_PIX;
					end
				end
				default: begin
					st_q <= S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// packet arguments and shared setup state
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			for (int i = 0; i < 6; i++) begin
				arg_q[i] <= 32'h0;
			end
			spitch_q <= 16'h0;
			cx1_q    <= 16'h0;
			cy1_q    <= 16'h0;
			cx2_q    <= 16'h0;
			cy2_q    <= 16'h0;
			fg_q     <= 32'h0;
			bg_q     <= 32'h0;
			base_q   <= 32'h0;
			srop_q   <= 8'h0;
		end else begin
			if (st_q == S_ARG && CMD_VALID) begin
				arg_q[argi_q] <= CMD_DATA;
			end
			// setup fields latch only from a setup packet
			if (st_q == S_GO && hdr_q[BPFM_HDR_OP +: 8] == BPFM_OP_SETUP) begin
				srop_q   <= hdr_q[BPFM_HDR_ROP +: 8];
				spitch_q <= arg_q[0][15:0];
				{cy1_q, cx1_q} <= arg_q[1];
				{cy2_q, cx2_q} <= arg_q[2];
				fg_q     <= arg_q[3];
				bg_q     <= arg_q[4];
				base_q   <= arg_q[5];
			end
		end
	end

	// ----------------------------------------------------------------
	// walk over the rectangle
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			x_q     <= 16'h0;
			y_q     <= 16'h0;
			xs_q    <= 16'h0;
			xe_q    <= 16'h0;
			ye_q    <= 16'h0;
			pitch_q <= 16'h0;
			line_q  <= 32'h0;
		end else if (st_q == S_GO && is_text_q) begin
			x_q     <= arg_q[0][15:0];
			y_q     <= arg_q[0][31:16];
			xs_q    <= arg_q[0][15:0];
			xe_q    <= arg_q[1][15:0];
			ye_q    <= arg_q[1][31:16];
			pitch_q <= spitch_q;
			// destination pitch only, no source pitch
			line_q  <= base_q + 32'(arg_q[0][31:16]) * 32'(spitch_q);
		end else if (st_q == S_GO) begin
			x_q     <= 16'h0;
			y_q     <= 16'h0;
			xs_q    <= 16'h0;
			// width in bytes, height in lines
			xe_q    <= arg_q[1][15:0] - 16'h0001;
			ye_q    <= arg_q[1][31:16] - 16'h0001;
			pitch_q <= arg_q[0][15:0];
			line_q  <= arg_q[2];
		end else if (st_q == S_NXT && !last_px) begin
			if (line_end) begin
				x_q    <= xs_q;
				y_q    <= y_q + 16'h0001;
				line_q <= line_q + {16'h0000, pitch_q};
			end else begin
				x_q <= x_q + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// memory datapath
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			addr_q  <= 32'h0;
			wdata_q <= 8'h0;
			for (int i = 0; i < 64; i++) begin
				pat_q[i] <= 8'h0;
			end
		end else begin
			if (st_q == S_GO) begin
				addr_q <= pbase;
			end else if (st_q == S_PATW) begin
				addr_q <= pbase + {25'h0, pcnt_q + 7'h1};
			end else begin
				addr_q <= pix_addr;
			end
			if (st_q == S_PATW && MEM_RVALID) begin
				pat_q[pcnt_q[5:0]] <= MEM_RDATA;
			end
			// the raster code combines pattern, source and destination bit by bit
			// fills carry no source operand, so no source fetch exists
			if (st_q == S_PIX || (st_q == S_DWT && MEM_RVALID)) begin
				wdata_q <= bpfm_rop(rop_c, pix_pat, pix_src, MEM_RDATA);
			end
		end
	end

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			run_q     <= BPFM_RUN_RST;
			err_q     <= 1'b0;
			done_q    <= 32'h0;
			REG_RDATA <= 32'h0;
		end else begin
			if (REG_WR && REG_ADDR == BPFM_REG_CTRL) begin
				run_q <= REG_WDATA[BPFM_CTRL_RUN];
			end
			// a new error in the clearing cycle stays set
			if ((take_hdr && op_in != BPFM_OP_FILL && op_in != BPFM_OP_SETUP && op_in != BPFM_OP_TEXT)
				|| (st_q == S_GO && is_text_q && hdr_q[BPFM_HDR_SRCSEL] != BPFM_SRC_STREAM)) begin
				err_q <= 1'b1;
			end else if (REG_WR && REG_ADDR == BPFM_REG_STATUS && REG_WDATA[BPFM_STAT_ERR]) begin
				err_q <= 1'b0;
			end
			if ((st_q == S_NXT && last_px) || (st_q == S_GO && hdr_q[BPFM_HDR_OP +: 8] == BPFM_OP_SETUP)) begin
				done_q <= done_q + 32'h1;
			end
			REG_RDATA <= 32'h0;
			if (REG_RD) begin
				case (REG_ADDR)
					BPFM_REG_CTRL:   REG_RDATA[BPFM_CTRL_RUN] <= run_q;
					BPFM_REG_STATUS: REG_RDATA <= {30'h0, err_q, BUSY};
					BPFM_REG_DONE:   REG_RDATA <= done_q;
					default:         REG_RDATA <= 32'h0;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking bpfm_cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	a_pat_copy_out: assert property (MEM_WR && !is_text_q && rop_c == BPFM_ROP_PAT |-> MEM_WDATA == pix_pat)
		else $error("pattern copy wrote a wrong value");
	a_src_copy_out: assert property (MEM_WR && is_text_q && rop_c == BPFM_ROP_SRC |-> MEM_WDATA == fg_q[7:0])
		else $error("source copy did not write the foreground");
	a_fill_no_src: assert property (MEM_RD && !is_text_q |-> st_q == S_PAT || uses_d)
		else $error("fill issued a read it does not need");
	a_pat_rd_need: assert property (st_q == S_PAT |-> uses_p && !is_text_q)
		else $error("pattern read without pattern use");
	a_pat_rd_addr: assert property (MEM_RD && st_q == S_PAT |-> MEM_ADDR == pbase + {25'h0, pcnt_q})
		else $error("pattern address not quadword based");
	a_first_dst_addr: assert property (MEM_WR && !is_text_q && x_q == 16'h0 && y_q == 16'h0
		|-> MEM_ADDR == arg_q[2])
		else $error("first fill write at wrong address");
	a_line_pitch: assert property (st_q == S_NXT && line_end && !last_px
		|=> line_q == $past(line_q) + {16'h0000, pitch_q} && x_q == xs_q)
		else $error("line step not equal to pitch");
	a_text_mask_clip: assert property (MEM_WR && is_text_q |-> gbit && in_clip)
		else $error("text wrote a masked or clipped pixel");
	a_one_packet: assert property (CMD_READY |-> st_q == S_IDLE || st_q == S_ARG || st_q == S_PIX)
		else $error("stream taken in the middle of a packet");
	a_write_gap: assert property (st_q == S_PIX && wen && !uses_d && !(is_text_q && !gv_q)
		|=> MEM_WR ##1 !MEM_WR)
		else $error("pixel write not issued one cycle after decision");

	c_fill_write: cover property (MEM_WR && !is_text_q ##1 st_q == S_PIX);
	c_text_write: cover property (MEM_WR && is_text_q);
	c_text_clipped: cover property (st_q == S_PIX && is_text_q && gv_q && gbit && !in_clip);
	c_pat_loaded: cover property (st_q == S_PATW && MEM_RVALID && pcnt_q == BPFM_PAT_LAST);
endmodule

// ---- verif/bpfm_mem_model.sv ----
/*
 * Frame-buffer memory model for the raster datapath bench.
 * Assumes one read outstanding at a time; writes are checked by the bench.
 */
module bpfm_mem_model
	import bpfm_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        mem_rd,
	input  wire logic [31:0] mem_addr,
	output logic      [7:0]  mem_rdata,
	output logic             mem_rvalid
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       pend;
	logic [7:0] val;
	int         wait_n;
	initial begin
		mem_rdata = 8'h00;
		mem_rvalid = 1'b0;
		pend = 1'b0;
	end
	// ------------------------------------------------------------
	// read return after a random 1..4 cycle latency
	// ------------------------------------------------------------
	always @(posedge clk) begin
		mem_rvalid <= 1'b0;
		// idle data keeps toggling so a stale byte is never mistaken for data
		mem_rdata <= ~mem_rdata;
		if (sys_rst) begin
			pend <= 1'b0;
		end else if (mem_rd) begin
			pend <= 1'b1;
			val <= mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h3c;
			wait_n <= $urandom_range(0, 3);
		end else if (pend) begin
			if (wait_n == 0) begin
				mem_rvalid <= 1'b1;
				mem_rdata <= val;
				pend <= 1'b0;
			end else begin
				wait_n <= wait_n - 1;
			end
		end
	end
endmodule

// ---- verif/tb.sv ----
/*
 * Self-checking bench: pattern fill and clipped mono text through the command stream.
 * Assumes the memory model answers every read; expectations are rebuilt here.
 */
module tb
	import bpfm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, sys_rst, reg_wr, reg_rd, cmd_valid, cmd_ready;
	logic        mem_rd, mem_wr, mem_rvalid, busy;
	logic [7:0]  reg_addr, mem_wdata, mem_rdata;
	logic [31:0] reg_wdata, reg_rdata, cmd_data, mem_addr, rv, d0;
	int          mismatches, num_checks;
	logic [31:0] rd_q[$], wa_q[$];
	logic [7:0]  wd_q[$];
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	bpfm_engine dut_u (.CLK(clk), .SYS_RST(sys_rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .CMD_DATA(cmd_data),
		.CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .MEM_RD(mem_rd), .MEM_WR(mem_wr),
		.MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata),
		.MEM_RVALID(mem_rvalid), .BUSY(busy));
	bpfm_mem_model mem_u (.clk(clk), .sys_rst(sys_rst), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] mem_val(input logic [31:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3c;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic close_out;
		if (mismatches == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge clk);
	endtask
	// word held until the edge that samples ready high
	task automatic send(input logic [31:0] w);
		int n;
		n = 0;
		cmd_data <= w;
		cmd_valid <= 1'b1;
		@(posedge clk);
		while (cmd_ready !== 1'b1 && n < 3000) begin
			n++;
			@(posedge clk);
		end
		if (n >= 3000) chk(32'h1, 32'h0, "stream stall");
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		cmd_valid <= 1'b0;
		cmd_data <= ~cmd_data;
		repeat (2) @(posedge clk);
		while (busy !== 1'b0 && n < 20000) begin
			n++;
			@(posedge clk);
		end
		if (n >= 20000) chk(32'h1, 32'h0, "engine stuck busy");
		repeat (3) @(posedge clk);
		chk(32'(wa_q.size() + rd_q.size()), 32'h0, "accesses missing");
	endtask
	// ------------------------------------------------------------
	// memory monitor
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (!sys_rst && mem_rd === 1'b1) begin
			chk(32'(cmd_ready), 32'h0, "stream taken mid packet");
			if (rd_q.size() == 0) chk(32'h1, 32'h0, "unexpected read");
			else chk(mem_addr, rd_q.pop_front(), "read addr");
		end
		if (!sys_rst && mem_wr === 1'b1) begin
			if (wa_q.size() == 0) chk(32'h1, 32'h0, "unexpected write");
			else begin
				chk(mem_addr, wa_q.pop_front(), "write addr");
				chk(32'(mem_wdata), 32'(wd_q.pop_front()), "write data");
			end
		end
	end
	// ------------------------------------------------------------
	// packets
	// ------------------------------------------------------------
	task automatic do_fill(input logic [15:0] w, input logic [15:0] h, input logic [31:0] dst,
		input logic [31:0] pa, input logic dyn, input logic [7:0] raster_operation_code);
		logic [31:0] pb, r, a;
		logic [15:0] pitch;
		logic [7:0]  p;
		pb = {pa[31:3], 3'h0};
		r = $urandom;
		pitch = 16'h0040 + 16'(r[20:12]);
		// no pattern fetch for a source copy, no access for an empty rectangle
		if ((dyn || raster_operation_code == BPFM_ROP_SRC) && w != 16'h0 && h != 16'h0) begin
			if (raster_operation_code != BPFM_ROP_SRC) begin
				for (int i = 0; i < 64; i++) rd_q.push_back(pb + 32'(i));
			end
			for (int y = 0; y < int'(h); y++) begin
				for (int x = 0; x < int'(w); x++) begin
					a = dst + 32'(y) * 32'(pitch) + 32'(x);
					p = mem_val(pb + 32'((y % 8) * 8 + x % 8));
					wa_q.push_back(a);
					// code 5a is pattern xor destination, so each pixel reads its destination first
					if (raster_operation_code == 8'h5a) rd_q.push_back(a);
					if (raster_operation_code == BPFM_ROP_SRC) wd_q.push_back(8'h00);
					else if (raster_operation_code == BPFM_ROP_PAT) wd_q.push_back(p);
					else wd_q.push_back(p ^ mem_val(a));
				end
			end
		end
		// top row first, ignored bits random
		send({BPFM_OP_FILL, raster_operation_code, r[9], 3'h0, dyn, BPFM_DEPTH_8BPP, r[8:0]});
		send({16'h0, pitch});
		send({h, w});
		send(dst);
		send(pa);
		wait_idle();
	endtask
	task automatic do_text(input int x1, input int y1, input int x2, input int y2,
		input int cx1, input int cy1, input int cx2, input int cy2);
		logic [31:0] g[$], fg, base, r;
		logic [15:0] pitch;
		int k;
		k = 0;
		r = $urandom;
		fg = $urandom;
		base = $urandom & 32'h00ff_fff0;
		pitch = 16'h0400;
		for (int y = y1; y <= y2; y++) begin
			for (int x = x1; x <= x2; x++) begin
				if (k % 32 == 0) g.push_back($urandom);
				if (g[k / 32][8 * ((k % 32) / 8) + 7 - k % 8] && x >= cx1 && x <= cx2 && y >= cy1 && y <= cy2) begin
					wa_q.push_back(base + 32'(y) * 32'(pitch) + 32'(x));
					wd_q.push_back(fg[7:0]);
				end
				k++;
			end
		end
		send({BPFM_OP_SETUP, BPFM_ROP_SRC, r[15:0]});
		send({16'h0, pitch});
		send({16'(cy1), 16'(cx1)});
		send({16'(cy2), 16'(cx2)});
		send(fg);
		send(~fg);
		send(base);
		send({BPFM_OP_TEXT, r[23:16], BPFM_SRC_STREAM, 6'h0, r[8:0]});
		send({16'(y1), 16'(x1)});
		send({16'(y2), 16'(x2)});
		foreach (g[i]) send(g[i]);
		wait_idle();
	endtask
	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		int x1, y1, x2, y2;
		{sys_rst, reg_wr, reg_rd, cmd_valid} = 4'hf;
		{reg_wr, reg_rd, cmd_valid} = 3'h0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		cmd_data = 32'h0;
		mismatches = 0;
		num_checks = 0;
		void'($urandom(32'h75d4));
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk(32'({busy, cmd_ready}), 32'h0, "idle after reset");
		reg_read(8'h40, rv);
		chk(rv, 32'h0, "unmapped read");
		reg_write(BPFM_REG_CTRL, 32'h1);
		reg_read(BPFM_REG_CTRL, rv);
		chk(rv, 32'h1, "run bit");
		reg_read(BPFM_REG_DONE, d0);
		do_fill(16'h0001, 16'h0001, 32'h0002_0080, 32'h0010_0000, 1'b1, BPFM_ROP_PAT);
		reg_read(BPFM_REG_DONE, rv);
		chk(rv, d0 + 32'h1, "done count");
		do_fill(16'h0009, 16'h0011, 32'h0002_0083, 32'h0010_0047, 1'b1, BPFM_ROP_PAT);
		do_fill(16'h0005, 16'h0003, 32'h0003_0000, 32'h0011_0000, 1'b0, BPFM_ROP_PAT);
		do_fill(16'h0006, 16'h0002, 32'h0004_0010, 32'h0012_0000, 1'b0, BPFM_ROP_SRC);
		do_fill(16'h0004, 16'h0003, 32'h0005_0001, 32'h0012_0008, 1'b1, 8'h5a);
		do_fill(16'h0000, 16'h0003, 32'h0006_0000, 32'h0013_0000, 1'b1, BPFM_ROP_PAT);
		for (int i = 0; i < 2; i++)
			do_fill(16'($urandom_range(1, 12)), 16'($urandom_range(1, 12)), $urandom, $urandom, 1'b1,
				BPFM_ROP_PAT);
		do_text(5, 3, 12, 10, 5, 3, 12, 10);
		do_text(5, 3, 12, 10, 7, 4, 7, 4);
		for (int i = 0; i < 3; i++) begin
			x1 = $urandom_range(1, 40);
			y1 = $urandom_range(1, 20);
			x2 = x1 + $urandom_range(0, 20);
			y2 = y1 + $urandom_range(0, 5);
			do_text(x1, y1, x2, y2, x1 - 1 + $urandom_range(0, 2), y1 - 1 + $urandom_range(0, 2),
				x2 - $urandom_range(0, 2), y2 + 1 - $urandom_range(0, 2));
		end
		send({8'h7e, 24'h0});
		wait_idle();
		reg_read(BPFM_REG_STATUS, rv);
		chk(rv, 32'h2, "error flag");
		reg_write(BPFM_REG_STATUS, 32'h2);
		reg_read(BPFM_REG_STATUS, rv);
		chk(rv, 32'h0, "error clear");
		// text without stream source is refused
		send({BPFM_OP_TEXT, BPFM_ROP_SRC, 1'b0, 15'h0});
		send(32'h0003_0002);
		send(32'h0005_0004);
		wait_idle();
		reg_read(BPFM_REG_STATUS, rv);
		chk(32'(rv[1]), 32'h1, "text source select error");
		close_out();
	end
	initial begin
		#2_000_000;
		mismatches++;
		close_out();
	end
endmodule
